// *** design/tap_pkg.sv ***
package tap_pkg;

    // instruction register: four code bits plus one parity bit on top
    localparam int          IR_W        = 4;
    localparam int          IR_SH_W     = IR_W + 1;
    localparam logic [4:0]  IR_CAPTURE  = 5'h01;

    // instruction codes
    localparam logic [3:0]  INS_EXTEST  = 4'h0;
    localparam logic [3:0]  INS_IDCODE  = 4'h1;
    localparam logic [3:0]  INS_SAMPLE  = 4'h2;
    localparam logic [3:0]  INS_INTEST  = 4'h3;
    localparam logic [3:0]  INS_CONTROL = 4'h8;
    localparam logic [3:0]  INS_FRONT   = 4'h9;
    localparam logic [3:0]  INS_STATUS  = 4'hA;
    localparam logic [3:0]  INS_CORE    = 4'hB;
    localparam logic [3:0]  INS_BIST    = 4'hC;
    localparam logic [3:0]  INS_GPO     = 4'hD;
    localparam logic [3:0]  INS_BYPASS  = 4'hF;

    // register banks reachable from the port
    localparam int          BANK_W      = 12;
    localparam int          CTRL_REGS   = 16;
    localparam int          STAT_REGS   = 6;
    localparam int          CTRL_BITS   = BANK_W * CTRL_REGS;
    localparam int          STAT_BITS   = BANK_W * STAT_REGS;

    // hardware error word, parity error of a loaded instruction
    localparam int          ERR_W       = 13;
    localparam int          ERR_BIT_IR  = 8;
    localparam int          BIST_BITS   = 2;
    localparam int          ID_BITS     = 32;

    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PAU_DR,
        TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR,
        TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
    } tap_state_t;

    typedef enum logic [3:0] {
        SEL_BYPASS, SEL_ID, SEL_BSR, SEL_CTRL, SEL_FRONT, SEL_STAT, SEL_CORE,
        SEL_BIST, SEL_GPO
    } dr_sel_t;

endpackage : tap_pkg

// *** design/jtag_test_access_port.sv ***
`timescale 1ns/1ns
module jtag_test_access_port
    import tap_pkg::*;
#(
    parameter int                  BSR_LEN  = 16,
    parameter int                  CORE_LEN = 32,
    parameter int                  GPO_W    = 12,
    parameter logic [ID_BITS-1:0]  ID_VALUE = 32'h1234_5001 // arbitrary value
)
(
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    input  wire logic                       tck,
    input  wire logic                       tms,
    input  wire logic                       tdi,
    output logic                            tdo_q,
    output logic                            tdo_oe_q,
    input  wire logic [BSR_LEN-1:0]         pin_state,
    input  wire logic [BSR_LEN-1:0]         core_resp,
    output logic      [BSR_LEN-1:0]         bsr_upd_q,
    output logic                            bsr_pin_drive_q,
    output logic                            bsr_core_drive_q,
    input  wire logic [tap_pkg::CTRL_BITS-1:0] ctrl_rd,
    output logic      [tap_pkg::CTRL_BITS-1:0] ctrl_wr_q,
    output logic                            ctrl_wr_stb_q,
    input  wire logic [tap_pkg::STAT_BITS-1:0] stat_rd,
    input  wire logic [CORE_LEN-1:0]        core_dbg_rd,
    output logic      [CORE_LEN-1:0]        core_dbg_wr_q,
    output logic                            core_dbg_stb_q,
    output logic                            bist_start_q,
    input  wire logic                       bist_done,
    input  wire logic                       bist_fail,
    output logic      [GPO_W-1:0]           gpo_q,
    output logic                            fe_tck_q,
    output logic                            fe_tms_q,
    output logic                            fe_tdi_q,
    input  wire logic                       fe_tdo,
    input  wire logic                       err_clear,
    output logic      [tap_pkg::ERR_W-1:0]  hw_err_q
);
    import tap_pkg::*;
    localparam int DR_MAX = (CTRL_BITS > BSR_LEN && CTRL_BITS > CORE_LEN) ? CTRL_BITS
                          : (BSR_LEN > CORE_LEN ? BSR_LEN : CORE_LEN);
    // refuse sizes the shared shift register cannot hold
    if (BSR_LEN < 1 || CORE_LEN < 1 || GPO_W < 1 || GPO_W > DR_MAX)
    begin : g_size_check
        $error("jtag_test_access_port: unsupported register length");
    end
    // decode of an instruction into the data register it selects
    function automatic dr_sel_t decode(input logic [IR_W-1:0] ins);
        case (ins)
            INS_EXTEST, INS_SAMPLE, INS_INTEST: decode = SEL_BSR;
            INS_IDCODE:  decode = SEL_ID;
            INS_CONTROL: decode = SEL_CTRL;
            INS_FRONT:   decode = SEL_FRONT;
            INS_STATUS:  decode = SEL_STAT;
            INS_CORE:    decode = SEL_CORE;
            INS_BIST:    decode = SEL_BIST;
            INS_GPO:     decode = SEL_GPO;
            default:     decode = SEL_BYPASS;
        endcase
    endfunction : decode
    // length of the selected data register
    function automatic int dr_len(input dr_sel_t sel);
        case (sel)
            SEL_ID:   dr_len = ID_BITS;
            SEL_BSR:  dr_len = BSR_LEN;
            SEL_CTRL: dr_len = CTRL_BITS;
            SEL_STAT: dr_len = STAT_BITS;
            SEL_CORE: dr_len = CORE_LEN;
            SEL_BIST: dr_len = BIST_BITS;
            SEL_GPO:  dr_len = GPO_W;
            default:  dr_len = 1;
        endcase
    endfunction : dr_len
    logic          tck_s1_q, tck_s2_q, tck_s3_q;
    logic          tms_s1_q, tms_s2_q;
    logic          tdi_s1_q, tdi_s2_q;
    logic          fdo_s1_q, fdo_s2_q;
    logic          tck_rise, tck_fall;
    tap_state_t    state_q, state_d;
    logic [IR_SH_W-1:0] ir_sh_q;
    logic [IR_W-1:0]    ins_q;
    dr_sel_t       sel;
    logic [DR_MAX-1:0]  dr_q;
    logic          ir_par_bad;
    // two flops on each test pin; tck gets a third stage for edge finding
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {tck_s1_q, tck_s2_q, tck_s3_q} <= 3'h0;
            {tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q} <= 4'hF;
            {fdo_s1_q, fdo_s2_q} <= 2'h0;
        end
        else
        begin
            tck_s1_q <= tck;
            tck_s2_q <= tck_s1_q;
            tck_s3_q <= tck_s2_q;
            tms_s1_q <= tms;
            tms_s2_q <= tms_s1_q;
            tdi_s1_q <= tdi;
            tdi_s2_q <= tdi_s1_q;
            fdo_s1_q <= fe_tdo;
            fdo_s2_q <= fdo_s1_q;
        end
    end
    assign tck_rise   = tck_s2_q & ~tck_s3_q;
    assign tck_fall   = ~tck_s2_q & tck_s3_q;
    assign sel        = decode(ins_q);
    assign ir_par_bad = ^ir_sh_q; // even parity over code and parity bit
    // standard sixteen-state controller, stepped on each tck rise
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            TS_RESET:  state_d = tms_s2_q ? TS_RESET  : TS_IDLE;
            TS_IDLE:   state_d = tms_s2_q ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: state_d = tms_s2_q ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: state_d = tms_s2_q ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR:  state_d = tms_s2_q ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: state_d = tms_s2_q ? TS_UPD_DR : TS_PAU_DR;
            TS_PAU_DR: state_d = tms_s2_q ? TS_EX2_DR : TS_PAU_DR;
            TS_EX2_DR: state_d = tms_s2_q ? TS_UPD_DR : TS_SH_DR;
            TS_UPD_DR: state_d = tms_s2_q ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: state_d = tms_s2_q ? TS_RESET  : TS_CAP_IR;
            TS_CAP_IR: state_d = tms_s2_q ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR:  state_d = tms_s2_q ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: state_d = tms_s2_q ? TS_UPD_IR : TS_PAU_IR;
            TS_PAU_IR: state_d = tms_s2_q ? TS_EX2_IR : TS_PAU_IR;
            TS_EX2_IR: state_d = tms_s2_q ? TS_UPD_IR : TS_SH_IR;
            TS_UPD_IR: state_d = tms_s2_q ? TS_SEL_DR : TS_IDLE;
            default:   state_d = TS_RESET;
        endcase
    end
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= TS_RESET;
        else if (tck_rise)
            state_q <= state_d;
    end
    // instruction shift and update; a bad parity loads bypass instead
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            {ir_sh_q, ins_q} <= {IR_CAPTURE, INS_IDCODE};
        else if (tck_rise)
        begin
            case (state_q)
                TS_RESET:  ins_q   <= INS_IDCODE;
                TS_CAP_IR: ir_sh_q <= IR_CAPTURE;
                TS_SH_IR:  ir_sh_q <= {tdi_s2_q, ir_sh_q[IR_SH_W-1:1]};
                TS_UPD_IR: ins_q   <= ir_par_bad ? INS_BYPASS : ir_sh_q[IR_W-1:0];
                default:   ins_q   <= ins_q;
            endcase
        end
    end
    // parity error flag; a new error wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            hw_err_q <= '0;
        else if (tck_rise && state_q == TS_UPD_IR && ir_par_bad)
            hw_err_q[ERR_BIT_IR] <= 1'b1;
        else if (err_clear)
            hw_err_q[ERR_BIT_IR] <= 1'b0;
    end
    // one shared data shift register: capture at lsb, tdi enters at length-1
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            dr_q <= '0;
        else if (tck_rise && state_q == TS_CAP_DR)
        begin
            dr_q <= '0;
            case (sel)
                SEL_ID:   dr_q[ID_BITS-1:0]   <= ID_VALUE;
                SEL_BSR:  dr_q[BSR_LEN-1:0]   <= (ins_q == INS_INTEST) ? core_resp
                                                 : pin_state;
                SEL_CTRL: dr_q[CTRL_BITS-1:0] <= ctrl_rd;
                SEL_STAT: dr_q[STAT_BITS-1:0] <= stat_rd;
                SEL_CORE: dr_q[CORE_LEN-1:0]  <= core_dbg_rd;
                SEL_BIST: dr_q[BIST_BITS-1:0] <= {bist_fail, bist_done};
                SEL_GPO:  dr_q[GPO_W-1:0]     <= gpo_q;
                default:  dr_q[0]             <= 1'b0;
            endcase
        end
        else if (tck_rise && state_q == TS_SH_DR)
        begin
            for (int i = 0; i < DR_MAX; i++)
                dr_q[i] <= (i == dr_len(sel) - 1) ? tdi_s2_q
                         : ((i < DR_MAX - 1) ? dr_q[(i + 1) % DR_MAX] : 1'b0);
        end
    end
    // update-dr effects of the writable registers
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bsr_upd_q      <= '0;
            ctrl_wr_q      <= '0;
            ctrl_wr_stb_q  <= 1'b0;
            core_dbg_wr_q  <= '0;
            core_dbg_stb_q <= 1'b0;
            gpo_q          <= '0;
        end
        else
        begin
            ctrl_wr_stb_q  <= 1'b0;
            core_dbg_stb_q <= 1'b0;
            if (tck_rise && state_q == TS_UPD_DR)
            begin
                case (sel)
                    SEL_BSR:
                    begin
                        if (ins_q != INS_SAMPLE) // sample must not disturb the chip
                            bsr_upd_q <= dr_q[BSR_LEN-1:0];
                    end
                    SEL_CTRL:
                    begin
                        ctrl_wr_q     <= dr_q[CTRL_BITS-1:0];
                        ctrl_wr_stb_q <= 1'b1;
                    end
                    SEL_CORE:
                    begin
                        core_dbg_wr_q  <= dr_q[CORE_LEN-1:0];
                        core_dbg_stb_q <= 1'b1;
                    end
                    SEL_GPO: gpo_q <= dr_q[GPO_W-1:0];
                    default: gpo_q <= gpo_q;
                endcase
            end
        end
    end
    // drive modes follow the loaded instruction; bist starts on idle entry, also
    // straight from update-ir, where the new code is not yet in ins_q
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            {bsr_pin_drive_q, bsr_core_drive_q, bist_start_q} <= 3'h0;
        else
        begin
            bsr_pin_drive_q  <= (ins_q == INS_EXTEST);
            bsr_core_drive_q <= (ins_q == INS_INTEST);
            bist_start_q     <= tck_rise && state_q != TS_IDLE && state_d == TS_IDLE
                                && (state_q == TS_UPD_IR
                                    ? (!ir_par_bad && ir_sh_q[IR_W-1:0] == INS_BIST)
                                    : sel == SEL_BIST);
        end
    end
    // front-end chain: mirror the test pins while its instruction is loaded
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            {fe_tck_q, fe_tms_q, fe_tdi_q} <= 3'h0;
        else if (sel == SEL_FRONT)
            {fe_tck_q, fe_tms_q, fe_tdi_q} <= {tck_s2_q, tms_s2_q, tdi_s2_q};
        else
            {fe_tck_q, fe_tms_q, fe_tdi_q} <= 3'h0;
    end
    // tdo changes on the falling tck edge; the front-end tdo passes our own
    // output register too, so that chain reads one bit longer
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            {tdo_q, tdo_oe_q} <= 2'h0;
        else if (tck_fall)
        begin
            tdo_oe_q <= (state_q == TS_SH_DR) || (state_q == TS_SH_IR);
            if (state_q == TS_SH_IR)
                tdo_q <= ir_sh_q[0];
            else if (sel == SEL_FRONT)
                tdo_q <= fdo_s2_q;
            else
                tdo_q <= dr_q[0];
        end
    end
endmodule : jtag_test_access_port

// *** testbench/jtag_tap_props.sv ***
`timescale 1ns/1ns
module jtag_tap_props
    import tap_pkg::*;
#(
    parameter int CORE_LEN = 32
)
(
    input wire logic                          core_clk,
    input wire logic                          arst_n,
    input wire logic                          tck,
    input wire logic                          tdo_q,
    input wire logic                          bsr_pin_drive_q,
    input wire logic                          bsr_core_drive_q,
    input wire logic [tap_pkg::CTRL_BITS-1:0] ctrl_wr_q,
    input wire logic                          ctrl_wr_stb_q,
    input wire logic [CORE_LEN-1:0]           core_dbg_wr_q,
    input wire logic                          core_dbg_stb_q,
    input wire logic                          bist_start_q,
    input wire logic                          fe_tck_q,
    input wire logic                          err_clear,
    input wire logic [tap_pkg::ERR_W-1:0]     hw_err_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // strobes are single pulses, and written data moves only with its strobe
    ctrl_pulse_a: assert property (ctrl_wr_stb_q |=> !ctrl_wr_stb_q)
        else $error("control strobe longer than one cycle");
    ctrl_gate_a: assert property (!$stable(ctrl_wr_q) |-> ctrl_wr_stb_q)
        else $error("control data moved without strobe");
    core_gate_a: assert property (!$stable(core_dbg_wr_q) |-> core_dbg_stb_q)
        else $error("core debug data moved without strobe");
    bist_pulse_a: assert property (bist_start_q |=> !bist_start_q)
        else $error("self test start longer than one cycle");
    // parity flag is sticky until cleared; the other error bits stay low
    err_hold_a: assert property (hw_err_q[8] && !err_clear |=> hw_err_q[8])
        else $error("parity flag dropped without clear");
    err_bits_a: assert property ({hw_err_q[12:9], hw_err_q[7:0]} == 12'h000)
        else $error("unused error bit set");
    drive_excl_a: assert property (!(bsr_pin_drive_q && bsr_core_drive_q))
        else $error("pins and core driven together");
    // tdo may only move once tck is low, else the controller samples a moving bit
    tdo_fall_a: assert property (!$stable(tdo_q) |-> !$past(tck))
        else $error("tdo changed while tck high");
    fe_follow_a: assert property (fe_tck_q |-> $past(tck, 2) || $past(tck, 3) || $past(tck, 4))
        else $error("front-end clock high without test clock");
    ctrl_wr_c: cover property (ctrl_wr_stb_q);
    bist_run_c: cover property (bist_start_q);
    parity_err_c: cover property ($rose(hw_err_q[8]));
    fe_clock_c: cover property ($rose(fe_tck_q));
endmodule : jtag_tap_props

bind jtag_test_access_port jtag_tap_props #(.CORE_LEN(CORE_LEN)) i_jtag_tap_props (
    .core_clk(core_clk), .arst_n(arst_n), .tck(tck), .tdo_q(tdo_q),
    .bsr_pin_drive_q(bsr_pin_drive_q), .bsr_core_drive_q(bsr_core_drive_q),
    .ctrl_wr_q(ctrl_wr_q), .ctrl_wr_stb_q(ctrl_wr_stb_q), .core_dbg_wr_q(core_dbg_wr_q),
    .core_dbg_stb_q(core_dbg_stb_q), .bist_start_q(bist_start_q), .fe_tck_q(fe_tck_q),
    .err_clear(err_clear), .hw_err_q(hw_err_q));

// *** testbench/jtag_ctrl_model.sv ***
`timescale 1ns/1ns
// far-side test controller; tck stands low between bits and between frames
module jtag_ctrl_model
(
    input  wire logic core_clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // idle levels at time zero
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 80 ns tck period; tdo is taken at the rising edge, before it can move
    task step(input logic m, input logic d, output logic o);
        @(posedge core_clk);
        tms <= m;
        tdi <= d;
        repeat (3) @(posedge core_clk);
        o = tdo;
        tck <= 1'b1;
        repeat (4) @(posedge core_clk);
        tck <= 1'b0;
    endtask : step
    // lsb first, tms high on the last bit, then update and back to idle
    task shift(input int n, input logic [191:0] din, output logic [191:0] dout);
        logic o;
        dout = '0;
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask : shift
    // idle to shift-ir, then the five instruction bits
    task ir(input logic [4:0] v);
        logic         o;
        logic [191:0] q;
        for (int i = 0; i < 4; i++) step(i < 2, 1'b0, o);
        shift(5, {187'd0, v}, q);
    endtask : ir
    // idle to shift-dr through capture
    task dr(input int n, input logic [191:0] din, output logic [191:0] dout);
        logic o;
        for (int i = 0; i < 3; i++) step(i == 0, 1'b0, o);
        shift(n, din, dout);
    endtask : dr
endmodule : jtag_ctrl_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    import tap_pkg::*;
    logic                 core_clk, tck, tms, tdi, tdo_q, tdo_oe_q, o, fe_tck_q, fe_tms_q;
    logic                 arst_n = 1'b0, err_clear = 1'b0, bist_done = 1'b0, bist_fail = 1'b0;
    logic                 fe_tdo = 1'b0, fe_tck_d = 1'b0, fe_tdi_q, ctrl_wr_stb_q;
    logic                 bsr_pin_drive_q, bsr_core_drive_q, core_dbg_stb_q, bist_start_q;
    logic [15:0]          pin_state = '0, core_resp = '0, bsr_upd_q;
    logic [CTRL_BITS-1:0] ctrl_rd = '0, ctrl_wr_q;
    logic [STAT_BITS-1:0] stat_rd = '0;
    logic [31:0]          core_dbg_rd = '0, core_dbg_wr_q;
    logic [11:0]          gpo_q;
    logic [ERR_W-1:0]     hw_err_q;
    logic [3:0]           fe_sr = '0;
    logic [3:0]           fe_ms = '0;
    logic                 oe_seen = 1'b0;
    logic [191:0]         q;
    int                   err_total = 0, n_compared = 0, n_bist = 0;
    jtag_test_access_port i_jtag_test_access_port (.*);
    jtag_ctrl_model i_jtag_ctrl_model (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo_q));
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // front-end chip: four-bit chain on its tck rise, its own tdo register on the fall;
    // also logs the mirrored tms, counts self test starts and notes tdo enable
    always @(posedge core_clk)
    begin
        fe_tck_d <= fe_tck_q;
        if (fe_tck_q && !fe_tck_d)
        begin
            fe_sr <= {fe_tdi_q, fe_sr[3:1]};
            fe_ms <= {fe_tms_q, fe_ms[3:1]};
        end
        if (!fe_tck_q && fe_tck_d)
            fe_tdo <= fe_sr[0];
        if (bist_start_q === 1'b1)
            n_bist++;
        if (tdo_oe_q === 1'b1)
            oe_seen <= 1'b1;
    end
    task chk(input logic [191:0] seen, input logic [191:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // bad set means the parity bit is flipped on purpose
    task load(input logic [3:0] c, input logic bad);
        i_jtag_ctrl_model.ir({(^c) ^ bad, c});
    endtask : load
    task dr(input int n, input logic [191:0] d);
        i_jtag_ctrl_model.dr(n, d, q);
    endtask : dr
    task t_bypass;
        logic [3:0] codes [6];
        codes = '{4'hf, 4'h4, 4'h5, 4'h6, 4'h7, 4'he};
        foreach (codes[i])
        begin
            load(codes[i], 1'b0);
            dr(8, 8'h6b);
            chk(q[7:1], 7'h6b);
        end
    endtask : t_bypass
    task t_bsr;
        logic [3:0]  codes [3];
        logic [15:0] din;
        codes = '{INS_SAMPLE, INS_EXTEST, INS_INTEST};
        pin_state <= 16'h9c31;
        core_resp <= 16'h42e7;
        foreach (codes[i])
        begin
            din = 16'h7a18 + 16'(i);
            load(codes[i], 1'b0);
            dr(16, din);
            chk(q[15:0], codes[i] == INS_INTEST ? core_resp : pin_state);
            chk(bsr_upd_q, codes[i] == INS_SAMPLE ? 16'h0000 : din);
            chk({bsr_pin_drive_q, bsr_core_drive_q},
                {codes[i] == INS_EXTEST, codes[i] == INS_INTEST});
        end
    endtask : t_bsr
    task t_banks;
        ctrl_rd <= {16{12'h5a3}};
        stat_rd <= {6{12'h3e1}};
        load(INS_CONTROL, 1'b0);
        dr(CTRL_BITS, {16{12'hc96}});
        chk(q, {16{12'h5a3}});
        chk(ctrl_wr_q, {16{12'hc96}});
        load(INS_STATUS, 1'b0);
        dr(STAT_BITS, '0);
        chk(q[71:0], {6{12'h3e1}});
    endtask : t_banks
    task t_core_gpo;
        core_dbg_rd <= 32'h3c5a_0ff1;
        load(INS_CORE, 1'b0);
        dr(32, 32'h96e1_2d07);
        chk(q[31:0], 32'h3c5a_0ff1);
        chk(core_dbg_wr_q, 32'h96e1_2d07);
        load(INS_GPO, 1'b0);
        dr(12, 12'hb4d);
        chk(gpo_q, 12'hb4d);
    endtask : t_core_gpo
    task t_bist;
        bist_fail <= 1'b1;
        n_bist = 0;
        load(INS_BIST, 1'b0);
        repeat (2) @(posedge core_clk); // let the counter see the last pulse
        chk(n_bist, 1);
        dr(2, '0);
        chk(q[1:0], 2'b10);
        repeat (2) @(posedge core_clk);
        chk(n_bist, 2);
    endtask : t_bist
    // bad parity falls back to bypass and raises the sticky flag
    task t_parity;
        load(INS_CONTROL, 1'b1);
        dr(8, 8'h6b);
        chk(q[7:1], 7'h6b);
        chk(hw_err_q[8], 1'b1);
        err_clear <= 1'b1;
        @(posedge core_clk);
        err_clear <= 1'b0;
        @(posedge core_clk);
        chk(hw_err_q[8], 1'b0);
    endtask : t_parity
    // front chain of four plus two tdo registers shows as five bits of delay
    task t_front;
        load(INS_FRONT, 1'b0);
        dr(16, 16'hc5a3);
        chk(q[15:5], 11'h5a3);
        repeat (2) @(posedge core_clk);
        chk(fe_ms, 4'b0110);
    endtask : t_front
    task results;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    initial
    begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        i_jtag_ctrl_model.step(1'b0, 1'b0, o);
        dr(ID_BITS, '0);
        chk(q[31:0], 32'h1234_5001);
        chk({oe_seen, tdo_oe_q}, 2'b10);
        t_bypass;
        t_bsr;
        t_banks;
        t_core_gpo;
        t_bist;
        t_parity;
        t_front;
        results;
    end
    // the tests need about 6k cycles; stop a hang at 60k
    initial
    begin
        #600000;
        err_total++;
        results;
    end
endmodule : tb_top
